//--- design/tcch_pkg.sv
// Purpose: shared constants for the tag custom command handler
// Assumes: 40 MHz system clock
// Notes:   reply and command codes, prolog layout, timing counts
package tcch_pkg;
  // select-answer interface bytes
  localparam logic [3:0] TCCH_GUARD_IDX    = 4'h0;
  localparam logic [5:0] TCCH_OPT_UPPER    = 6'h00;
  localparam logic [1:0] TCCH_OPT_CID_NAD  = 2'h2;
  // prolog byte layout
  localparam int         TCCH_PCB_CID_BIT  = 3;
  localparam logic [7:0] TCCH_PCB_MASK     = 8'hf7;
  localparam logic [7:0] TCCH_PCB_VALUE    = 8'h55;
  // information field codes
  localparam logic [7:0] TCCH_CMD_WAKE     = 8'h01;
  localparam logic [7:0] TCCH_CMD_READ     = 8'h02;
  localparam logic [7:0] TCCH_CMD_WRITE    = 8'h04;
  localparam logic [7:0] TCCH_ST_OK        = 8'h90;
  localparam logic [7:0] TCCH_ST_ERR       = 8'h61;
  // word array geometry
  localparam int         TCCH_WORDS        = 32;
  localparam logic [3:0] TCCH_MAX_READ     = 4'h8;
  // programming delay
  localparam int         TCCH_CLK_HZ       = 40000000;
  localparam int         TCCH_PROG_US      = 8000;
  localparam int         TCCH_PROG_CYC     =
    (TCCH_CLK_HZ / 1000000) * TCCH_PROG_US;
endpackage

//--- design/tcch_skid.sv
// Purpose: two-entry byte buffer between reply builder and framer
// Assumes: single clock, synchronous active-high reset
// Notes:   ready toward source only depends on occupancy
`timescale 1ns/1ps
`default_nettype none
module tcch_skid
  import tcch_pkg::*;
#(
  parameter int W = 9
) (
  // clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // fill side
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  // drain side
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic [1:0]        cnt;
  } tcch_skid_t;
  tcch_skid_t st, next_st;
  logic push, pop;

  // handshake terms
  assign in_ready_out  = (st.cnt != 2'h2);
  assign out_valid_out = (st.cnt != 2'h0);
  assign out_data_out  = st.mem[0];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  // shift-register fifo, head at entry 0
  always_comb begin
    next_st = st;
    if (pop) begin
      next_st.mem[0] = st.mem[1];
    end
    if (push) begin
      if (st.cnt == 2'h0 || (st.cnt == 2'h1 && pop)) begin
        next_st.mem[0] = in_data_in;
      end else begin
        next_st.mem[1] = in_data_in;
      end
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

//--- design/tcch_top.sv
// Purpose: custom command decode and reply for a contactless tag
// Assumes: framer delivers deframed, crc-checked block bytes
// Notes:   reply bytes carry a last flag; crc appended by the framer
// Function
// - frame-timing byte is wait index over four zero guard bits.
// - option byte is six zeros, identifier supported, node address not.
// - blocks are control byte, optional identifier, data, two crc bytes.
// - control byte must match fixed pattern; bit 3 flags identifier byte.
// - wake command 01h is echoed and pulses the wake interrupt.
// - word address is address byte shifted right by one.
// - read request is 02h, first address, word count.
// - good read replies 90h then four to thirty-two data bytes.
// - counts above eight are clipped to eight words.
// - read-locked words return zeros.
// - addresses past the array end return zeros.
// - read starting beyond the array replies just 61h.
// - write request is 04h, address, four data bytes.
// - each write is answered with one status byte.
// - power check by dummy program; failure skips write, replies error.
// - real programming delays the write reply by about 8 ms.
`timescale 1ns/1ps
`default_nettype none
module tcch_top
  import tcch_pkg::*;
#(
  parameter int PROG_CYC = TCCH_PROG_CYC
) (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // configuration
  input  wire logic [3:0] fwi_in,
  output logic [7:0]      tb1_out,
  output logic [7:0]      tc1_out,
  // received block bytes, last byte flagged, crc removed
  input  wire logic       rx_valid_in,
  input  wire logic [7:0] rx_data_in,
  input  wire logic       rx_last_in,
  output logic            rx_ready_out,
  // reply bytes toward framer, crc added there
  output logic            tx_valid_out,
  output logic [7:0]      tx_data_out,
  output logic            tx_last_out,
  input  wire logic       tx_ready_in,
  // word array port
  output logic [4:0]      mem_addr_out,
  input  wire logic [31:0] mem_rdata_in,
  input  wire logic       mem_rlock_in,
  output logic            mem_prog_out,
  output logic            mem_dummy_out,
  output logic [31:0]     mem_wdata_out,
  input  wire logic       mem_done_in,
  input  wire logic       mem_pwr_ok_in,
  // host side
  output logic            wake_irq_out
);
  typedef enum {S_RX, S_DEC, S_PCB, S_CID, S_CMD, S_RD_HDR, S_RD_DAT,
                S_CHK, S_PROG, S_WAIT, S_ONE, S_DROP} tcch_state_t;
  typedef struct packed {
    tcch_state_t state;
    logic [7:0][7:0] buf_b;
    logic [3:0]  nrx;
    logic        ovf;
    logic [7:0]  pcb;
    logic [7:0]  one;
    logic [5:0]  waddr;
    logic [3:0]  left;
    logic [1:0]  bidx;
    logic [31:0] word;
    logic [22:0] tmr;
    logic        wake;
    logic        prog;
    logic        dummy;
  } tcch_st_t;
  tcch_st_t st, next_st;

  logic       q_valid, q_ready, q_last;
  logic [7:0] q_data;
  logic [3:0] inf0;

  // select-answer bytes, wait index from fwi_in, rest fixed
  assign tb1_out = {fwi_in, TCCH_GUARD_IDX};
  assign tc1_out = {TCCH_OPT_UPPER, TCCH_OPT_CID_NAD};

  // word array drive
  assign mem_addr_out  = st.waddr[4:0];
  assign mem_wdata_out = {st.buf_b[6], st.buf_b[5], st.buf_b[4],
                          st.buf_b[3]};
  assign mem_prog_out  = st.prog;
  assign mem_dummy_out = st.dummy;
  assign wake_irq_out  = st.wake;
  assign rx_ready_out  = (st.state == S_RX);

  // information field starts after prolog
  assign inf0 = st.pcb[TCCH_PCB_CID_BIT] ? 4'h2 : 4'h1;

  // main sequencer
  always_comb begin
    next_st = st;
    next_st.wake  = 1'b0;
    q_valid = 1'b0;
    q_data  = 8'h00;
    q_last  = 1'b0;
    case (st.state)
      S_RX: begin
        if (rx_valid_in) begin
          if (st.nrx == 4'h8) begin
            next_st.ovf = 1'b1;
          end else begin
            next_st.buf_b[st.nrx[2:0]] = rx_data_in;
            next_st.nrx = st.nrx + 4'h1;
          end
          if (rx_last_in) begin
            next_st.state = S_DEC;
          end
        end
      end
      S_DEC: begin
        next_st.pcb = st.buf_b[0];
        if ((st.buf_b[0] & TCCH_PCB_MASK) != TCCH_PCB_VALUE) begin
          next_st.state = S_DROP;
        end else begin
          next_st.state = S_PCB;
        end
      end
      S_PCB: begin
        // reply prolog echoes request control byte
        q_valid = 1'b1;
        q_data  = st.pcb;
        if (q_ready) begin
          next_st.state = st.pcb[TCCH_PCB_CID_BIT] ? S_CID : S_CMD;
        end
      end
      S_CID: begin
        q_valid = 1'b1;
        q_data  = st.buf_b[1];
        if (q_ready) begin
          next_st.state = S_CMD;
        end
      end
      S_CMD: begin
        next_st.waddr = {1'b0, st.buf_b[inf0 + 4'h1][7:3]} |
                        {st.buf_b[inf0 + 4'h1][7:6] != 2'h0, 5'h00};
        next_st.waddr[4:0] = st.buf_b[inf0 + 4'h1][5:1];
        next_st.one = TCCH_ST_ERR;
        next_st.state = S_ONE;
        if (st.ovf) begin
          next_st.state = S_ONE;
        end else if (st.buf_b[inf0] == TCCH_CMD_WAKE &&
                     st.nrx == inf0 + 4'h1) begin
          next_st.one  = TCCH_CMD_WAKE;
          next_st.wake = 1'b1;
        end else if (st.buf_b[inf0] == TCCH_CMD_READ &&
                     st.nrx == inf0 + 4'h3) begin
          // start addresses beyond array end, or zero count, give error only
          if (st.buf_b[inf0 + 4'h1][7:6] == 2'h0 &&
              st.buf_b[inf0 + 4'h2] != 8'h00) begin
            next_st.state = S_RD_HDR;
            next_st.left  = (st.buf_b[inf0 + 4'h2] > 8'h08) ?
                            TCCH_MAX_READ :
                            st.buf_b[inf0 + 4'h2][3:0];
          end
        end else if (st.buf_b[inf0] == TCCH_CMD_WRITE &&
                     st.nrx == inf0 + 4'h6 && inf0 == 4'h1 &&
                     st.buf_b[inf0 + 4'h1][7:6] == 2'h0) begin
          next_st.dummy = 1'b1;
          next_st.state = S_CHK;
        end
      end
      S_RD_HDR: begin
        q_valid = 1'b1;
        q_data  = TCCH_ST_OK;
        next_st.bidx = 2'h0;
        if (q_ready) begin
          next_st.state = S_RD_DAT;
        end
      end
      S_RD_DAT: begin
        // zero for locked or absent words
        q_valid = 1'b1;
        q_data  = (st.waddr[5] || mem_rlock_in) ? 8'h00 :
                  mem_rdata_in[8*st.bidx +: 8];
        q_last  = (st.bidx == 2'h3) && (st.left == 4'h1);
        if (q_ready) begin
          next_st.bidx = st.bidx + 2'h1;
          if (st.bidx == 2'h3) begin
            next_st.waddr = st.waddr + 6'h01;
            next_st.left  = st.left - 4'h1;
            if (st.left == 4'h1) begin
              next_st.state = S_RX;
              next_st.nrx   = 4'h0;
            end
          end
        end
      end
      S_CHK: begin
        if (mem_done_in) begin
          next_st.dummy = 1'b0;
          if (mem_pwr_ok_in) begin
            next_st.prog  = 1'b1;
            next_st.tmr   = 23'(PROG_CYC);
            next_st.state = S_PROG;
          end else begin
            next_st.one   = TCCH_ST_ERR;
            next_st.state = S_ONE;
          end
        end
      end
      S_PROG: begin
        // hold reply for the full programming time
        next_st.prog = 1'b0;
        next_st.state = S_WAIT;
      end
      S_WAIT: begin
        next_st.tmr = st.tmr - 23'h1;
        if (st.tmr == 23'h1) begin
          next_st.one   = TCCH_ST_OK;
          next_st.state = S_ONE;
        end
      end
      S_ONE: begin
        q_valid = 1'b1;
        q_data  = st.one;
        q_last  = 1'b1;
        if (q_ready) begin
          next_st.state = S_RX;
          next_st.nrx   = 4'h0;
          next_st.ovf   = 1'b0;
        end
      end
      S_DROP: begin
        next_st.state = S_RX;
        next_st.nrx   = 4'h0;
        next_st.ovf   = 1'b0;
      end
      default: begin
        next_st.state = S_RX;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st <= '0;
      st.state <= S_RX;
    end else begin
      st <= next_st;
    end
  end

  // reply buffer toward framer
  tcch_skid #(.W(9)) u_skid (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (q_valid),
    .in_data_in    ({q_last, q_data}),
    .in_ready_out  (q_ready),
    .out_valid_out (tx_valid_out),
    .out_data_out  ({tx_last_out, tx_data_out}),
    .out_ready_in  (tx_ready_in)
  );

  // checks
  property p_tb1;
    @(posedge sys_clk_in) disable iff (rst_in)
      tb1_out[3:0] == 4'h0 && tb1_out[7:4] == fwi_in;
  endproperty
  a_tb1: assert property (p_tb1) else $error("tb1 wrong");

  property p_tc1;
    @(posedge sys_clk_in) disable iff (rst_in) tc1_out == 8'h02;
  endproperty
  a_tc1: assert property (p_tc1) else $error("tc1 wrong");

  property p_pcb;
    @(posedge sys_clk_in) disable iff (rst_in)
      st.state == S_PCB |-> (st.pcb & 8'hf7) == 8'h55;
  endproperty
  a_pcb: assert property (p_pcb) else $error("prolog byte");

  property p_wake;
    @(posedge sys_clk_in) disable iff (rst_in)
      wake_irq_out |-> st.one == TCCH_CMD_WAKE && st.state == S_ONE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake bad");

  property p_count;
    @(posedge sys_clk_in) disable iff (rst_in)
      st.state == S_RD_HDR |-> st.left <= 4'h8 && st.left != 4'h0;
  endproperty
  a_count: assert property (p_count) else $error("count");

  property p_zero;
    @(posedge sys_clk_in) disable iff (rst_in)
      (st.state == S_RD_DAT && (st.waddr[5] || mem_rlock_in))
      |-> q_data == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("not zero");

  property p_hdr;
    @(posedge sys_clk_in) disable iff (rst_in)
      st.state == S_RD_HDR |-> q_data == 8'h90;
  endproperty
  a_hdr: assert property (p_hdr) else $error("hdr");

  property p_fail;
    @(posedge sys_clk_in) disable iff (rst_in)
      (st.state == S_CHK && mem_done_in && !mem_pwr_ok_in)
      |=> st.state == S_ONE && st.one == 8'h61 && !mem_prog_out;
  endproperty
  a_fail: assert property (p_fail) else $error("pwr fail");

  sequence s_prog_start;
    st.state == S_CHK && mem_done_in && mem_pwr_ok_in;
  endsequence
  property p_delay;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_prog_start |=> mem_prog_out ##1 st.state == S_WAIT [*8];
  endproperty
  a_delay: assert property (p_delay) else $error("delay");
endmodule
`default_nettype wire

//--- bench/tcch_mem_model.sv
// Purpose: word array model facing the command handler
// Assumes: combinational read, power check answered after four cycles
// Notes:   word 5 is read-locked; pwr_ok is only valid with done
`timescale 1ns/1ps
`default_nettype none
module tcch_mem_model (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // word array port
  input  wire logic [4:0]  addr_in,
  input  wire logic        prog_in,
  input  wire logic        dummy_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        pwr_cfg_in,
  output logic [31:0]      rdata_out,
  output logic             rlock_out,
  output logic             done_out,
  output logic             pwr_ok_out
);
  logic [31:0] mem [32];
  logic [1:0]  cnt;
  logic        armed;
  // fixed fill pattern
  initial for (int i = 0; i < 32; i++) mem[i] = {i[7:0], 8'h3c, ~i[7:0], 8'h5a};
  // read path, lock flag for one word
  assign rdata_out = mem[addr_in];
  assign rlock_out = (addr_in == 5'h05);
  // outside done the level is the wrong one, never a free pass
  assign pwr_ok_out = done_out ? pwr_cfg_in : ~pwr_cfg_in;
  // power check answer and programming
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt <= 2'h0;
      armed <= 1'b1;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (dummy_in && armed) begin
        cnt <= cnt + 2'h1;
        if (cnt == 2'h3) begin
          done_out <= 1'b1;
          armed <= 1'b0;
        end
      end
      if (!dummy_in) begin
        armed <= 1'b1;
        cnt <= 2'h0;
      end
      if (prog_in) mem[addr_in] <= wdata_in;
    end
  end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Purpose: self-checking bench for the custom command handler
// Assumes: programming delay shortened to 20 cycles
// Notes:   random reads and reply stalls from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tcch_pkg::*;
  typedef logic [7:0] tcch_bq_t[$];
  localparam int PC = 20;
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [3:0]  fwi_in = 4'h0;
  logic        rx_valid_in = 1'b0;
  logic        rx_last_in = 1'b0;
  logic        tx_ready_in = 1'b0;
  logic        pwr_cfg = 1'b1;
  logic [7:0]  rx_data_in = 8'h00;
  logic [7:0]  tb1_out, tc1_out, tx_data_out;
  logic        rx_ready_out, tx_valid_out, tx_last_out, mem_prog_out;
  logic        mem_dummy_out, mem_done_in, mem_pwr_ok_in, mem_rlock_in;
  logic        wake_irq_out;
  logic [4:0]  mem_addr_out;
  logic [31:0] mem_rdata_in, mem_wdata_out;
  logic [31:0] sh [32];
  tcch_bq_t    rq;
  int          mismatches = 0, checks = 0, wakes = 0, progs = 0, got = 0;
  integer      seed = 32'had39a142;

  tcch_top #(.PROG_CYC(PC)) DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .fwi_in(fwi_in), .tb1_out(tb1_out), .tc1_out(tc1_out),
    .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
    .rx_last_in(rx_last_in), .rx_ready_out(rx_ready_out),
    .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
    .tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in),
    .mem_addr_out(mem_addr_out), .mem_rdata_in(mem_rdata_in),
    .mem_rlock_in(mem_rlock_in), .mem_prog_out(mem_prog_out),
    .mem_dummy_out(mem_dummy_out), .mem_wdata_out(mem_wdata_out),
    .mem_done_in(mem_done_in), .mem_pwr_ok_in(mem_pwr_ok_in),
    .wake_irq_out(wake_irq_out));
  tcch_mem_model MEM (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .addr_in(mem_addr_out), .prog_in(mem_prog_out),
    .dummy_in(mem_dummy_out), .wdata_in(mem_wdata_out),
    .pwr_cfg_in(pwr_cfg), .rdata_out(mem_rdata_in),
    .rlock_out(mem_rlock_in), .done_out(mem_done_in),
    .pwr_ok_out(mem_pwr_ok_in));

  // clock
  always #12.5 sys_clk_in = ~sys_clk_in;
  // reply collection and event counts
  always @(posedge sys_clk_in) begin
    if (tx_valid_out && tx_ready_in) begin
      rq.push_back(tx_data_out);
      if (tx_last_out) got++;
    end
    if (wake_irq_out) wakes++;
    if (mem_prog_out) progs++;
  end
  // random stalls on the reply side
  always @(negedge sys_clk_in) if (!rst_in) tx_ready_in <= ($random(seed) % 3) != 0;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // one block, each byte held until taken
  task automatic send(tcch_bq_t b);
    int w;
    foreach (b[i]) begin
      @(negedge sys_clk_in);
      rx_valid_in = 1'b1;
      rx_data_in = b[i];
      rx_last_in = (i == b.size() - 1);
      w = 0;
      do @(posedge sys_clk_in); while (rx_ready_out !== 1'b1 && w++ < 50);
      chk("rx_taken", 1, w <= 50);
    end
    @(negedge sys_clk_in);
    rx_valid_in = 1'b0;
    rx_last_in = 1'b0;
  endtask

  // send a block, wait for the whole reply, compare it
  task automatic xfer(tcch_bq_t c, tcch_bq_t e, int lim, output int lat);
    rq.delete();
    got = 0;
    send(c);
    lat = 0;
    while (got == 0 && lat++ < lim) @(posedge sys_clk_in);
    #1;
    chk("reply_seen", e.size() != 0, got != 0);
    chk("reply_len", e.size(), rq.size());
    foreach (e[i]) if (i < rq.size()) chk("reply_byte", e[i], rq[i]);
  endtask

  // expected read reply from the shadow copy
  function automatic tcch_bq_t rd_exp(logic [7:0] ab, logic [7:0] n);
    tcch_bq_t    e;
    int          a;
    logic [31:0] w;
    e = '{8'h55};
    if (ab[7:1] > 7'd31 || n == 8'h00) begin
      e.push_back(8'h61);
      return e;
    end
    e.push_back(8'h90);
    for (int i = 0; i < ((n > 8) ? 8 : n); i++) begin
      a = ab[7:1] + i;
      w = (a > 31 || a == 5) ? 32'h0 : sh[a];
      for (int k = 0; k < 4; k++) e.push_back(w[8*k +: 8]);
    end
    return e;
  endfunction

  initial begin
    tcch_bq_t   none;
    int         lat;
    logic [7:0] ab, n;
    for (int i = 0; i < 32; i++) sh[i] = {i[7:0], 8'h3c, ~i[7:0], 8'h5a};
    repeat (5) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_in = 1'b0;
    // select-answer bytes for every wait index
    for (int f = 0; f < 16; f++) begin
      @(negedge sys_clk_in);
      fwi_in = f[3:0];
      #1;
      chk("tb1", {f[3:0], 4'h0}, tb1_out);
      chk("tc1", 8'h02, tc1_out);
    end
    xfer('{8'h55, 8'h01}, '{8'h55, 8'h01}, 50, lat);
    chk("wake", 1, wakes);
    xfer('{8'h5d, 8'h07, 8'h01}, '{8'h5d, 8'h07, 8'h01}, 50, lat);
    chk("wake2", 2, wakes);
    xfer('{8'h54, 8'h01}, none, 30, lat);
    // bits 5 and 4 reversed is a reserved prolog, dropped
    xfer('{8'h65, 8'h01}, none, 30, lat);
    xfer('{8'h55, 8'h07}, '{8'h55, 8'h61}, 50, lat);
    xfer('{8'h55, 8'h02, 8'h40, 8'h01}, '{8'h55, 8'h61}, 50, lat);
    xfer('{8'h55, 8'h02, 8'h3d, 8'h08}, rd_exp(8'h3d, 8'h08), 300, lat);
    // random reads over the whole valid range
    repeat (12) begin
      ab = 8'({$random(seed)} % 64);
      n = 8'({$random(seed)} % 13);
      xfer('{8'h55, 8'h02, ab, n}, rd_exp(ab, n), 300, lat);
    end
    xfer('{8'h55, 8'h04, 8'h15, 8'hde, 8'had, 8'hbe, 8'hef},
         '{8'h55, 8'h90}, PC + 100, lat);
    chk("prog_wait", 1, lat >= PC);
    // first data byte lands in bits 7:0, read back first
    sh[10] = 32'hefbeadde;
    xfer('{8'h55, 8'h02, 8'h14, 8'h01}, rd_exp(8'h14, 8'h01), 100, lat);
    // failed power check leaves the word alone
    pwr_cfg = 1'b0;
    xfer('{8'h55, 8'h04, 8'h14, 8'h11, 8'h22, 8'h33, 8'h44},
         '{8'h55, 8'h61}, PC + 100, lat);
    chk("no_wait", 1, lat < PC);
    chk("progs", 1, progs);
    pwr_cfg = 1'b1;
    xfer('{8'h55, 8'h02, 8'h14, 8'h01}, rd_exp(8'h14, 8'h01), 100, lat);
    chk("wake_total", 2, wakes);
    finish_test();
  end

  // watchdog
  initial begin
    #(25 * 50000);
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire
